// file: hdl/cod_pkg.sv
package cod_pkg;

  // first opcode bytes recognised by the decoder
  localparam logic [7:0] OPC_MOV_TO_SEG      = 8'h8e;
  localparam logic [7:0] OPC_MOV_FROM_SEG    = 8'h8c;
  localparam logic [7:0] OPC_TABLE_TRANSLATE = 8'hd7;
  localparam logic [7:0] OPC_LOAD_EFF_ADDR   = 8'h8d;
  localparam logic [7:0] OPC_PTR_LOAD_DATA   = 8'hc5;
  localparam logic [7:0] OPC_PTR_LOAD_EXTRA  = 8'hc4;
  localparam logic [7:0] OPC_FLAGS_TO_HIGH   = 8'h9f;
  localparam logic [7:0] OPC_HIGH_TO_FLAGS   = 8'h9e;
  localparam logic [7:0] OPC_FLAGS_PUSH      = 8'h9c;
  localparam logic [7:0] OPC_FLAGS_POP       = 8'h9d;
  localparam logic [7:0] OPC_BCD_ADD_UNP     = 8'h37;
  localparam logic [7:0] OPC_BCD_SUB_UNP     = 8'h3f;
  localparam logic [7:0] OPC_BCD_ADD_PKD     = 8'h27;
  localparam logic [7:0] OPC_BCD_SUB_PKD     = 8'h2f;
  localparam logic [6:0] OPC_MULDIV_GROUP    = 7'h7b;  // 1111011w
  localparam logic [5:0] OPC_SMUL_IMM_HI     = 6'h1a;  // 011010s1

  // addressing byte fields
  localparam logic [2:0] REG_UMUL    = 3'h4;
  localparam logic [2:0] REG_SMUL    = 3'h5;
  localparam logic [2:0] REG_UDIV    = 3'h6;
  localparam logic [1:0] MOD_NODISP  = 2'h0;
  localparam logic [1:0] MOD_DISP8   = 2'h1;
  localparam logic [1:0] MOD_DISP16  = 2'h2;
  localparam logic [1:0] MOD_REG     = 2'h3;
  localparam logic [2:0] RM_DIRECT   = 3'h6;

  // minimum clock charges
  localparam logic [5:0] CLK_SEG_REG        = 6'h02;
  localparam logic [5:0] CLK_TO_SEG_MEM     = 6'h09;
  localparam logic [5:0] CLK_FROM_SEG_MEM   = 6'h0b;
  localparam logic [5:0] CLK_TABLE_XLT      = 6'h0b;
  localparam logic [5:0] CLK_EFF_ADDR       = 6'h06;
  localparam logic [5:0] CLK_PTR_LOAD       = 6'h12;
  localparam logic [5:0] CLK_FLAGS_TO_HIGH  = 6'h02;
  localparam logic [5:0] CLK_HIGH_TO_FLAGS  = 6'h03;
  localparam logic [5:0] CLK_FLAGS_PUSH     = 6'h09;
  localparam logic [5:0] CLK_FLAGS_POP      = 6'h08;
  localparam logic [5:0] CLK_BCD_ADD_UNP    = 6'h08;
  localparam logic [5:0] CLK_BCD_SUB_UNP    = 6'h07;
  localparam logic [5:0] CLK_BCD_PKD        = 6'h04;
  localparam logic [5:0] CLK_UMUL_RB        = 6'h1a;
  localparam logic [5:0] CLK_UMUL_RW        = 6'h23;
  localparam logic [5:0] CLK_UMUL_MB        = 6'h20;
  localparam logic [5:0] CLK_UMUL_MW        = 6'h29;
  localparam logic [5:0] CLK_SMUL_RB        = 6'h19;
  localparam logic [5:0] CLK_SMUL_RW        = 6'h22;
  localparam logic [5:0] CLK_SMUL_MB        = 6'h1f;
  localparam logic [5:0] CLK_SMUL_MW        = 6'h28;
  localparam logic [5:0] CLK_SMUL_IMM_R     = 6'h16;
  localparam logic [5:0] CLK_SMUL_IMM_M     = 6'h1d;
  localparam logic [5:0] CLK_UDIV_RB        = 6'h1d;
  localparam logic [5:0] CLK_UDIV_RW        = 6'h26;
  localparam logic [5:0] CLK_UDIV_MB        = 6'h23;
  localparam logic [5:0] CLK_UDIV_MW        = 6'h2c;
  // worst extra clocks from the unit-to-unit handoff
  localparam logic [1:0] MAX_HANDOFF_EXTRA  = 2'h2;

  typedef enum logic [4:0] {
    OP_NONE, OP_MOV_TO_SEG, OP_MOV_FROM_SEG, OP_TABLE_TRANSLATE,
    OP_LOAD_EFF_ADDR, OP_PTR_LOAD_DATA, OP_PTR_LOAD_EXTRA,
    OP_FLAGS_TO_HIGH, OP_HIGH_TO_FLAGS, OP_FLAGS_PUSH, OP_FLAGS_POP,
    OP_BCD_ADD_UNP, OP_BCD_SUB_UNP, OP_BCD_ADD_PKD, OP_BCD_SUB_PKD,
    OP_UMUL, OP_SMUL, OP_SMUL_IMM, OP_UDIV
  } cod_op_t;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_MODRM  = 7'h02,
    ST_DISPLO = 7'h04,
    ST_DISPHI = 7'h08,
    ST_IMMLO  = 7'h10,
    ST_IMMHI  = 7'h20,
    ST_EXEC   = 7'h40
  } cod_state_t;

  // decoded instruction, held stable from decode through completion
  typedef struct packed {
    cod_op_t     op;
    logic        word;
    logic        mem;
    logic [1:0]  mode;
    logic [2:0]  reg_sel;
    logic [2:0]  rm;
    logic [15:0] disp;
    logic [15:0] imm;
    logic [5:0]  charge;
  } cod_decode_t;

endpackage : cod_pkg

// file: hdl/cod_decode_timing.sv
`timescale 1ns/100ps
module cod_decode_timing
  import cod_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_q_valid,
  input  wire logic  [7:0] i_q_byte,
  input  wire logic  i_handoff_stall,
  output logic       o_q_take,
  output cod_decode_t o_dec,
  output logic       o_busy,
  output logic       o_done,
  output logic       o_illegal,
  output logic       o_unknown
);

  cod_state_t  state;
  cod_state_t  next_state;
  logic [5:0]  remain;
  logic [1:0]  extra;
  logic        take;
  logic        needs_disp;
  logic        disp_two;
  logic [6:0]  exec_len;
  cod_op_t     next_op;
  logic [5:0]  next_charge;

  // minimum charge from operation, width and operand kind
  function automatic logic [5:0] charge_f(cod_op_t op, logic w, logic m);
    case (op)
      OP_MOV_TO_SEG:      charge_f = m ? CLK_TO_SEG_MEM : CLK_SEG_REG;
      OP_MOV_FROM_SEG:    charge_f = m ? CLK_FROM_SEG_MEM : CLK_SEG_REG;
      OP_TABLE_TRANSLATE: charge_f = CLK_TABLE_XLT;
      OP_LOAD_EFF_ADDR:   charge_f = CLK_EFF_ADDR;
      OP_PTR_LOAD_DATA:   charge_f = CLK_PTR_LOAD;
      OP_PTR_LOAD_EXTRA:  charge_f = CLK_PTR_LOAD;
      OP_FLAGS_TO_HIGH:   charge_f = CLK_FLAGS_TO_HIGH;
      OP_HIGH_TO_FLAGS:   charge_f = CLK_HIGH_TO_FLAGS;
      OP_FLAGS_PUSH:      charge_f = CLK_FLAGS_PUSH;
      OP_FLAGS_POP:       charge_f = CLK_FLAGS_POP;
      OP_BCD_ADD_UNP:     charge_f = CLK_BCD_ADD_UNP;
      OP_BCD_SUB_UNP:     charge_f = CLK_BCD_SUB_UNP;
      OP_BCD_ADD_PKD:     charge_f = CLK_BCD_PKD;
      OP_BCD_SUB_PKD:     charge_f = CLK_BCD_PKD;
      OP_UMUL: charge_f = m ? (w ? CLK_UMUL_MW : CLK_UMUL_MB)
                            : (w ? CLK_UMUL_RW : CLK_UMUL_RB);
      OP_SMUL: charge_f = m ? (w ? CLK_SMUL_MW : CLK_SMUL_MB)
                            : (w ? CLK_SMUL_RW : CLK_SMUL_RB);
      OP_SMUL_IMM: charge_f = m ? CLK_SMUL_IMM_M : CLK_SMUL_IMM_R;
      OP_UDIV: charge_f = m ? (w ? CLK_UDIV_MW : CLK_UDIV_MB)
                            : (w ? CLK_UDIV_RW : CLK_UDIV_RB);
      default: charge_f = CLK_SEG_REG;
    endcase
  endfunction : charge_f

  // op and charge as they will stand once this byte is captured; the
  // countdown loads from here because o_dec is still one edge behind
  always_comb begin
    next_op     = o_dec.op;
    next_charge = o_dec.charge;
    if (state == ST_IDLE) begin
      case (i_q_byte)
        OPC_FLAGS_TO_HIGH: next_charge = CLK_FLAGS_TO_HIGH;
        OPC_HIGH_TO_FLAGS: next_charge = CLK_HIGH_TO_FLAGS;
        OPC_FLAGS_PUSH:    next_charge = CLK_FLAGS_PUSH;
        OPC_FLAGS_POP:     next_charge = CLK_FLAGS_POP;
        OPC_BCD_ADD_UNP:   next_charge = CLK_BCD_ADD_UNP;
        OPC_BCD_SUB_UNP:   next_charge = CLK_BCD_SUB_UNP;
        OPC_BCD_ADD_PKD:   next_charge = CLK_BCD_PKD;
        OPC_BCD_SUB_PKD:   next_charge = CLK_BCD_PKD;
        default:           next_charge = CLK_TABLE_XLT;
      endcase
    end else if (state == ST_MODRM) begin
      if (o_dec.op == OP_NONE) begin
        case (i_q_byte[5:3])
          REG_UMUL: next_op = OP_UMUL;
          REG_SMUL: next_op = OP_SMUL;
          REG_UDIV: next_op = OP_UDIV;
          default:  next_op = OP_NONE;
        endcase
      end
      if (next_op != OP_NONE)
        next_charge = charge_f(next_op, o_dec.word,
                               i_q_byte[7:6] != MOD_REG);
    end
  end

  // displacement length from the addressing byte
  always_comb begin
    needs_disp = 1'b0;
    disp_two   = 1'b0;
    case (i_q_byte[7:6])
      MOD_DISP8:  needs_disp = 1'b1;
      MOD_DISP16: begin
        needs_disp = 1'b1;
        disp_two   = 1'b1;
      end
      MOD_NODISP: begin
        needs_disp = (i_q_byte[2:0] == RM_DIRECT);
        disp_two   = (i_q_byte[2:0] == RM_DIRECT);
      end
      default: needs_disp = 1'b0;  // register form
    endcase
  end

  // bytes are only taken while present; an empty queue just stalls
  assign take     = i_q_valid && (state != ST_EXEC);
  assign o_q_take = take;
  assign o_busy   = (state != ST_IDLE);

  // sequencing through opcode, addressing, displacement, immediate
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          case (i_q_byte)
            OPC_MOV_TO_SEG, OPC_MOV_FROM_SEG, OPC_LOAD_EFF_ADDR,
            OPC_PTR_LOAD_DATA, OPC_PTR_LOAD_EXTRA:
              next_state = ST_MODRM;
            OPC_TABLE_TRANSLATE, OPC_FLAGS_TO_HIGH, OPC_HIGH_TO_FLAGS,
            OPC_FLAGS_PUSH, OPC_FLAGS_POP, OPC_BCD_ADD_UNP,
            OPC_BCD_SUB_UNP, OPC_BCD_ADD_PKD, OPC_BCD_SUB_PKD:
              next_state = ST_EXEC;
            default: begin
              if (i_q_byte[7:1] == OPC_MULDIV_GROUP ||
                  (i_q_byte[7:2] == OPC_SMUL_IMM_HI && i_q_byte[0]))
                next_state = ST_MODRM;
            end
          endcase
        end
      end
      ST_MODRM: begin
        if (take) begin
          if ((o_dec.op == OP_PTR_LOAD_DATA ||
               o_dec.op == OP_PTR_LOAD_EXTRA) &&
              i_q_byte[7:6] == MOD_REG)
            next_state = ST_IDLE;
          else if (o_dec.op == OP_NONE &&
                   !(i_q_byte[5:3] inside {REG_UMUL, REG_SMUL, REG_UDIV}))
            next_state = ST_IDLE;
          else if (needs_disp)
            next_state = ST_DISPLO;
          else if (o_dec.op == OP_SMUL_IMM)
            next_state = ST_IMMLO;
          else
            next_state = ST_EXEC;
        end
      end
      ST_DISPLO: begin
        if (take) begin
          if (o_dec.mode != MOD_DISP8)
            next_state = ST_DISPHI;
          else if (o_dec.op == OP_SMUL_IMM)
            next_state = ST_IMMLO;
          else
            next_state = ST_EXEC;
        end
      end
      ST_DISPHI: begin
        if (take)
          next_state = (o_dec.op == OP_SMUL_IMM) ? ST_IMMLO : ST_EXEC;
      end
      ST_IMMLO: begin
        // s bit set means one immediate byte, sign-extended
        if (take)
          next_state = o_dec.word ? ST_IMMHI : ST_EXEC;
      end
      ST_IMMHI: begin
        if (take)
          next_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (remain <= 6'h01 &&
            !(o_dec.mem && i_handoff_stall && extra < MAX_HANDOFF_EXTRA))
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // capture of decoded fields as bytes arrive
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dec <= '0;
    end else if (take) begin
      case (state)
        ST_IDLE: begin
          o_dec      <= '0;
          o_dec.word <= i_q_byte[0];
          case (i_q_byte)
            OPC_MOV_TO_SEG:      o_dec.op <= OP_MOV_TO_SEG;
            OPC_MOV_FROM_SEG:    o_dec.op <= OP_MOV_FROM_SEG;
            OPC_TABLE_TRANSLATE: o_dec.op <= OP_TABLE_TRANSLATE;
            OPC_LOAD_EFF_ADDR:   o_dec.op <= OP_LOAD_EFF_ADDR;
            OPC_PTR_LOAD_DATA:   o_dec.op <= OP_PTR_LOAD_DATA;
            OPC_PTR_LOAD_EXTRA:  o_dec.op <= OP_PTR_LOAD_EXTRA;
            OPC_FLAGS_TO_HIGH:   o_dec.op <= OP_FLAGS_TO_HIGH;
            OPC_HIGH_TO_FLAGS:   o_dec.op <= OP_HIGH_TO_FLAGS;
            OPC_FLAGS_PUSH:      o_dec.op <= OP_FLAGS_PUSH;
            OPC_FLAGS_POP:       o_dec.op <= OP_FLAGS_POP;
            OPC_BCD_ADD_UNP:     o_dec.op <= OP_BCD_ADD_UNP;
            OPC_BCD_SUB_UNP:     o_dec.op <= OP_BCD_SUB_UNP;
            OPC_BCD_ADD_PKD:     o_dec.op <= OP_BCD_ADD_PKD;
            OPC_BCD_SUB_PKD:     o_dec.op <= OP_BCD_SUB_PKD;
            default: begin
              if (i_q_byte[7:2] == OPC_SMUL_IMM_HI && i_q_byte[0]) begin
                o_dec.op   <= OP_SMUL_IMM;
                o_dec.word <= !i_q_byte[1];  // word immediate when s=0
              end
            end
          endcase
          // single-byte ops are fully known; charge now
          o_dec.charge <= next_charge;
        end
        ST_MODRM: begin
          o_dec.mode    <= i_q_byte[7:6];
          o_dec.reg_sel <= i_q_byte[5:3];
          o_dec.rm      <= i_q_byte[2:0];
          o_dec.mem     <= (i_q_byte[7:6] != MOD_REG);
          o_dec.op      <= next_op;
          o_dec.charge  <= next_charge;
        end
        ST_DISPLO: o_dec.disp <= {{8{i_q_byte[7]}}, i_q_byte};
        ST_DISPHI: o_dec.disp[15:8] <= i_q_byte;
        ST_IMMLO:  o_dec.imm  <= {{8{i_q_byte[7]}}, i_q_byte};
        ST_IMMHI:  o_dec.imm[15:8] <= i_q_byte;
        default:   o_dec.imm <= o_dec.imm;
      endcase
    end
  end

  // execution countdown; charges are whole, so a control transfer's
  // charge would already cover its destination fetch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      remain <= 6'h00;
      extra  <= 2'h0;
    end else if (state != ST_EXEC && next_state == ST_EXEC) begin
      remain <= next_charge;  // whole minimum charge
      extra  <= 2'h0;
    end else if (state == ST_EXEC) begin
      if (remain > 6'h01)
        remain <= remain - 6'h01;
      else if (o_dec.mem && i_handoff_stall && extra < MAX_HANDOFF_EXTRA)
        extra <= extra + 2'h1;
    end
  end

  // completion and fault pulses
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      o_unknown <= 1'b0;
    end else begin
      o_done    <= (state == ST_EXEC) && (next_state == ST_IDLE);
      o_illegal <= (state == ST_MODRM) && take &&
                   (o_dec.op == OP_PTR_LOAD_DATA ||
                    o_dec.op == OP_PTR_LOAD_EXTRA) &&
                   i_q_byte[7:6] == MOD_REG;
      o_unknown <= take && next_state == ST_IDLE &&
                   (state == ST_IDLE ||
                    (state == ST_MODRM && o_dec.op == OP_NONE));
    end
  end

  // helper: cycles spent in execution for the instruction just done
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      exec_len <= 7'h00;
    else if (state != ST_EXEC && next_state == ST_EXEC)
      exec_len <= 7'h01;
    else if (state == ST_EXEC && next_state == ST_EXEC)
      exec_len <= exec_len + 7'h01;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_TAKE_ONLY_VALID: assert property (o_q_take |-> i_q_valid)
    else $error("byte taken from empty queue");
  AST_EXTRA_BOUND: assert property (o_done |->
      exec_len <= {1'b0, o_dec.charge} + 7'h02
      && exec_len >= {1'b0, o_dec.charge})
    else $error("execution length outside charge window");
  AST_REG_EXACT: assert property (o_done && !o_dec.mem |->
      exec_len == {1'b0, o_dec.charge})
    else $error("register form did not take minimum count");
  AST_SEG_MOVE: assert property (o_done &&
      o_dec.op == OP_MOV_FROM_SEG
      |-> o_dec.charge == (o_dec.mem ? 6'h0b : 6'h02))
    else $error("segment store charge wrong");
  AST_TRANSLATE: assert property (o_done &&
      o_dec.op == OP_TABLE_TRANSLATE |-> exec_len == 7'h0b)
    else $error("table translate not 11 clocks");
  AST_PTR_REG_FORM: assert property (o_illegal |->
      !o_busy && $past(o_busy) && o_dec.mode == MOD_REG &&
      (o_dec.op == OP_PTR_LOAD_DATA || o_dec.op == OP_PTR_LOAD_EXTRA))
    else $error("pointer load register form not dropped");
  AST_MODE_REG: assert property (o_busy &&
      o_dec.mode == MOD_REG && o_dec.op != OP_NONE &&
      $past(state) != ST_IDLE |-> !o_dec.mem)
    else $error("register mode treated as memory");
  AST_DIRECT_ADDR: assert property (state == ST_MODRM && take &&
      i_q_byte[7:6] == MOD_NODISP && i_q_byte[2:0] == RM_DIRECT &&
      o_dec.op != OP_NONE |=> state == ST_DISPLO)
    else $error("direct address not fetched");
  AST_FLAGS_POP: assert property (o_done &&
      o_dec.op == OP_FLAGS_POP |-> exec_len == 7'h08)
    else $error("flags pop not 8 clocks");
  AST_UMUL_BYTE: assert property (o_done &&
      o_dec.op == OP_UMUL && !o_dec.mem && !o_dec.word
      |-> exec_len == 7'h1a)
    else $error("byte unsigned multiply not 26 clocks");

  COV_MEM_STALL: cover property (state == ST_EXEC && extra == 2'h2);
  COV_SMUL_IMM: cover property (o_done && o_dec.op == OP_SMUL_IMM);
  COV_UNKNOWN: cover property (o_unknown);
  COV_ILLEGAL: cover property (o_illegal);

endmodule : cod_decode_timing

// file: test/cod_queue_model.sv
`timescale 1ns/100ps
module cod_queue_model (
  input  wire logic       i_clk,
  input  wire logic       i_take,
  input  wire logic       i_hold,
  output logic            o_valid,
  output logic [7:0]      o_byte
);
  logic [7:0] fifo [$];
  logic [7:0] last = 8'h00;

  // bench hands over whole instructions, opcode first
  task automatic put(input logic [7:0] b);
    fifo.push_back(b);
  endtask : put

  // drop leftovers after a refused opcode, hide them at once
  task automatic flush();
    fifo.delete();
    o_valid = 1'b0;
  endtask : flush

  // head retires only on a taken edge; idle data is scrambled
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
    forever begin
      @(posedge i_clk);
      if (i_take === 1'b1 && fifo.size() > 0) begin
        last = fifo.pop_front();
      end
      #1;
      o_valid = !i_hold && fifo.size() > 0;
      o_byte  = o_valid ? fifo[0] : ~last;
    end
  end
endmodule : cod_queue_model

// file: test/cod_decode_timing_bench.sv
`timescale 1ns/100ps
module cod_decode_timing_bench;
  import cod_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_q_valid;
  logic [7:0]  i_q_byte;
  logic        i_handoff_stall = 1'b0;
  logic        o_q_take, o_busy, o_done, o_illegal, o_unknown;
  cod_decode_t o_dec;
  logic        hold = 1'b0;
  logic [31:0] seed = 32'h51da;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t_take = 0;
  logic [7:0]  ops [18] = '{8'h8e, 8'h8c, 8'hd7, 8'h8d, 8'hc5, 8'hc4,
    8'h9f, 8'h9e, 8'h9c, 8'h9d, 8'h37, 8'h3f, 8'h27, 8'h2f, 8'hf6, 8'hf7,
    8'h69, 8'h6b};
  cod_op_t     eops [18] = '{OP_MOV_TO_SEG, OP_MOV_FROM_SEG,
    OP_TABLE_TRANSLATE, OP_LOAD_EFF_ADDR, OP_PTR_LOAD_DATA, OP_PTR_LOAD_EXTRA,
    OP_FLAGS_TO_HIGH, OP_HIGH_TO_FLAGS, OP_FLAGS_PUSH, OP_FLAGS_POP,
    OP_BCD_ADD_UNP, OP_BCD_SUB_UNP, OP_BCD_ADD_PKD, OP_BCD_SUB_PKD,
    OP_UMUL, OP_UMUL, OP_SMUL_IMM, OP_SMUL_IMM};
  logic [15:0] hand [26] = '{16'hd700, 16'h9f00, 16'h9e00, 16'h9c00,
    16'h9d00, 16'h3700, 16'h3f00, 16'h2700, 16'h2f00, 16'h8ec3, 16'h8e06,
    16'h8c47, 16'h8c80, 16'h8d16, 16'hc546, 16'hc413, 16'hc5c0, 16'hc4d8,
    16'hf6e1, 16'hf7e9, 16'hf6f2, 16'hf726, 16'h6bc1, 16'h6905, 16'h9000,
    16'hf6c0};

  always #50 i_clk = ~i_clk;

  cod_decode_timing u_cod_decode_timing (
    .i_clk           (i_clk),
    .i_rstn          (i_rstn),
    .i_q_valid       (i_q_valid),
    .i_q_byte        (i_q_byte),
    .i_handoff_stall (i_handoff_stall),
    .o_q_take        (o_q_take),
    .o_dec           (o_dec),
    .o_busy          (o_busy),
    .o_done          (o_done),
    .o_illegal       (o_illegal),
    .o_unknown       (o_unknown)
  );

  cod_queue_model u_cod_queue_model (
    .i_clk   (i_clk),
    .i_take  (o_q_take),
    .i_hold  (hold),
    .o_valid (i_q_valid),
    .o_byte  (i_q_byte)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // minimum charge, -1 for opcodes or f6/f7 reg fields outside the decoded subset
  function automatic int chg(logic [7:0] op, logic [7:0] mr);
    logic m;
    logic w;
    m = mr[7:6] != 2'h3;
    w = op[0];
    case (op)
      8'h8e: return m ? 9 : 2;
      8'h8c: return m ? 11 : 2;
      8'hd7: return 11;
      8'h8d: return 6;
      8'hc4, 8'hc5: return 18;
      8'h9f: return 2;
      8'h9e: return 3;
      8'h9c: return 9;
      8'h9d: return 8;
      8'h37: return 8;
      8'h3f: return 7;
      8'h27, 8'h2f: return 4;
      8'h69, 8'h6b: return m ? 29 : 22;
      8'hf6, 8'hf7: begin
        case (mr[5:3])
          3'h4: return m ? (w ? 41 : 32) : (w ? 35 : 26);
          3'h5: return m ? (w ? 40 : 31) : (w ? 34 : 25);
          3'h6: return m ? (w ? CLK_UDIV_MW : CLK_UDIV_MB)
                         : (w ? CLK_UDIV_RW : 29);
          default: return -1;
        endcase
      end
      default: return -1;
    endcase
  endfunction : chg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // one instruction through the queue, then timing and fields
  task automatic run(input logic [7:0] op, input logic [7:0] mr,
                     input logic [15:0] d, input logic [15:0] im,
                     input logic st);
    int          ch;
    int          n;
    logic        hm;
    logic        m;
    logic [15:0] ed;
    cod_op_t     eo;
    ch = chg(op, mr);
    hm = op inside {8'h8e, 8'h8c, 8'h8d, 8'hc4, 8'hc5, 8'h69, 8'h6b,
                    8'hf6, 8'hf7};
    m  = hm && mr[7:6] != 2'h3;
    st = st && m;
    ed = 16'h0000;
    eo = OP_NONE;
    for (n = 0; n < 18; n++) begin
      if (ops[n] == op) eo = eops[n];
    end
    if (op[7:1] == 7'h7b) begin
      eo = mr[5:3] == 3'h4 ? OP_UMUL : (mr[5:3] == 3'h5 ? OP_SMUL : OP_UDIV);
    end
    i_handoff_stall = st;
    u_cod_queue_model.flush();
    u_cod_queue_model.put(op);
    if (hm) u_cod_queue_model.put(mr);
    if (m && mr[7:6] == 2'h1) begin
      u_cod_queue_model.put(d[7:0]);
      ed = {{8{d[7]}}, d[7:0]};
    end else if (m && (mr[7:6] == 2'h2 || mr[2:0] == 3'h6)) begin
      u_cod_queue_model.put(d[7:0]);
      u_cod_queue_model.put(d[15:8]);
      ed = d;
    end
    if (op[7:2] == 6'h1a) u_cod_queue_model.put(im[7:0]);
    if (op == 8'h69) u_cod_queue_model.put(im[15:8]);
    if (op == 8'h6b) im = {{8{im[7]}}, im[7:0]};
    for (n = 0; n < 200; n++) begin
      @(posedge i_clk);
      #1;
      if (o_done === 1'b1 || o_unknown === 1'b1 || o_illegal === 1'b1) break;
    end
    if (n == 200) begin
      fail_count++;
      complete_run();
    end else begin
      chk(o_unknown, ch < 0);
      chk(o_illegal, op[7:1] == 7'h62 && !m);
      if (ch >= 0 && !(op[7:1] == 7'h62 && !m)) begin
        chk(o_done, 1);
        chk(o_dec.op, eo);
        chk(o_dec.charge, ch);
        chk(o_dec.mem, m);
        chk(o_busy, 0);
        if (hm) chk({o_dec.mode, o_dec.reg_sel, o_dec.rm}, mr);
        if (m) chk(o_dec.disp, ed);
        if (op[7:1] == 7'h7b) chk(o_dec.word, op[0]);
        if (op[7:2] == 6'h1a) chk(o_dec.imm, im);
        n = cyc - t_take - 1;
        if (st) chk(n >= ch && n <= ch + 2, 1);
        else chk(n, ch);
      end
    end
  endtask : run

  // edge index that took the latest byte
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_q_take === 1'b1) t_take <= cyc;
  end

  // random queue gaps stand in for a slow prefetch
  always @(posedge i_clk) begin
    hold <= xs() % 5 == 0;
  end

  initial begin
    int          k;
    logic [31:0] r;
    logic [31:0] r2;
    logic [7:0]  op;
    logic [7:0]  mr;
    repeat (10) @(posedge i_clk);
    #1;
    chk(o_busy, 0);
    chk(o_done, 0);
    chk(o_dec.charge, 0);
    i_rstn = 1'b1;
    for (k = 0; k < 26; k++) begin
      r = xs();
      run(hand[k][15:8], hand[k][7:0], r[15:0], r[31:16], k[0]);
    end
    // reset in mid-execution must abandon the instruction
    u_cod_queue_model.flush();
    u_cod_queue_model.put(8'hd7);
    repeat (5) @(posedge i_clk);
    #1;
    i_rstn = 1'b0;
    #1;
    chk(o_busy, 0);
    chk(o_done, 0);
    @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    for (k = 0; k < 300; k++) begin
      r  = xs();
      r2 = xs();
      op = ops[r[31:24] % 18];
      mr = r[7:0];
      if (op == 8'h8d && mr[7:6] == 2'h3) mr[7:6] = 2'h2;
      if (op[7:1] == 7'h7b && !(mr[5:3] inside {3'h4, 3'h5, 3'h6})) begin
        mr[7:6] = 2'h3;
      end
      run(op, mr, r2[15:0], r2[31:16], r[8]);
    end
    complete_run();
  end
endmodule : cod_decode_timing_bench
